/* mmd_access_pkg.sv */
// constants and types shared by the indirect access register bank
package mmd_access_pkg;
  // widths
  localparam int REG_W = 16;
  localparam int OFF_W = 5;
  localparam int DEV_W = 5;
  localparam int NUM_MMD = 32;
  // register offsets on the management port
  localparam logic [OFF_W-1:0] OFF_GIG_STATUS = 5'h0a;
  localparam logic [OFF_W-1:0] OFF_PSE_CONTROL = 5'h0b;
  localparam logic [OFF_W-1:0] OFF_PSE_STATUS = 5'h0c;
  localparam logic [OFF_W-1:0] OFF_ACC_CONTROL = 5'h0d;
  localparam logic [OFF_W-1:0] OFF_ACC_DATA = 5'h0e;
  // field positions
  localparam int ACC_TYPE_HI = 15;
  localparam int ACC_TYPE_LO = 14;
  localparam int DEV_SEL_HI = 4;
  localparam int DEV_SEL_LO = 0;
  localparam int GIG_FD_BIT = 11;
  localparam int GIG_HD_BIT = 10;
  localparam int GIG_LOW_HI = 9;
  localparam int CTRL_GAP_W = 9;
  // reset values, zero word and pointer step
  localparam logic [REG_W-1:0] ACC_CONTROL_RESET = 16'h0000;
  localparam logic [REG_W-1:0] ACC_DATA_RESET = 16'h0000;
  localparam logic [REG_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [REG_W-1:0] ADDR_STEP = 16'h0001;
  // access type codes of the control register
  typedef enum logic [1:0] {
    ACC_ADDRESS = 2'b00,
    ACC_DATA = 2'b01,
    ACC_DATA_POST_INCREMENT_MODE = 2'b10,
    ACC_DATA_POST_INCREMENT_WRITE_MODE = 2'b11
  } access_type_t;
  // request sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_REPLY = 2'b10
  } seq_state_t;
endpackage

/* mmd_addr_if.sv */
// link between the register bank and the per-MMD address store
interface mmd_addr_if;
  import mmd_access_pkg::*;
  logic [DEV_W-1:0] sel;
  logic load;
  logic incr;
  logic [REG_W-1:0] load_data;
  logic [REG_W-1:0] cur_addr;
  modport ctl (output sel, output load, output incr, output load_data, input cur_addr);
  modport store (input sel, input load, input incr, input load_data, output cur_addr);
endinterface

/* mmd_addr_store.sv */
// one address register per MMD, loaded or stepped for the selected MMD only
module mmd_addr_store
  import mmd_access_pkg::*;
#(
  parameter int N = NUM_MMD
)
(
  // clock and control
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // access from the register bank
  mmd_addr_if.store acc
);
  typedef struct packed {
    logic [N-1:0][REG_W-1:0] addr;
  } store_t;

  store_t r;
  store_t next_r;
  wire logic [N-1:0][REG_W-1:0] next_addr;

  // only the entry named by sel moves, others keep their pointer
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_entry
      // one continuous assignment per entry keeps every slice single-driven
      assign next_addr[i] = (acc.sel != DEV_W'(i)) ? r.addr[i]
        : acc.load ? acc.load_data
        : acc.incr ? r.addr[i] + ADDR_STEP
        : r.addr[i];

      // entries of other MMDs keep their pointer
      AST_ENTRY_KEEP: assert property (@(posedge mclk) disable iff (sys_rst)
        (ce && acc.sel != DEV_W'(i)) |=> r.addr[i] == $past(r.addr[i]))
        else $error("unselected pointer moved");
    end
  endgenerate

  // gather entries into the state copy
  always_comb
  begin
    next_r = r;
    next_r.addr = next_addr;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      r <= '0;
    else if (ce)
      r <= next_r;
  end

  // pointer of the selected MMD
  assign acc.cur_addr = r.addr[acc.sel];
endmodule

/* mmd_indirect_access_regs.sv */
// management register bank: gigabit status tail, reserved pair, MMD indirect access
module mmd_indirect_access_regs
  import mmd_access_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // management register port
  input wire logic [OFF_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [REG_W-1:0] reg_wdata,
  output logic [REG_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_ready,
  // link partner abilities from the negotiation logic
  input wire logic partner_gig_full_duplex_able,
  input wire logic partner_gig_half_duplex_able,
  // MMD register space
  output logic [DEV_W-1:0] mmd_dev,
  output logic [REG_W-1:0] mmd_addr,
  output logic [REG_W-1:0] mmd_wdata,
  output logic mmd_rd,
  output logic mmd_wr,
  input wire logic [REG_W-1:0] mmd_rdata
);
  typedef struct packed {
    seq_state_t st;
    access_type_t access_type_field;
    logic [DEV_W-1:0] target_device_select;
    logic [OFF_W-1:0] req_off;
    logic req_wr;
    logic [REG_W-1:0] req_wdata;
    logic [REG_W-1:0] rd_data;
    logic rd_valid;
    logic mmd_rd;
    logic mmd_wr;
    logic [DEV_W-1:0] mmd_dev;
    logic [REG_W-1:0] mmd_addr;
    logic [REG_W-1:0] mmd_wdata;
  } bank_t;

  bank_t r;
  bank_t next_r;
  mmd_addr_if acc ();
  logic data_is_mmd;
  logic [REG_W-1:0] gigabit_status_reg;
  logic [REG_W-1:0] indirect_access_control_reg;
  logic [REG_W-1:0] indirect_access_data_reg;
  logic [CTRL_GAP_W-1:0] reserved_bits;

  // per-MMD pointers live in their own store
  mmd_addr_store #(
    .N(NUM_MMD)
  ) u_store (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .acc(acc)
  );

  // the store always follows the current device select
  assign acc.sel = r.target_device_select;
  assign data_is_mmd = (r.access_type_field != ACC_ADDRESS);
  assign reserved_bits = '0;

  // read views of the registers
  always_comb
  begin
    gigabit_status_reg = ZERO_WORD;
    gigabit_status_reg[GIG_FD_BIT] = partner_gig_full_duplex_able;
    gigabit_status_reg[GIG_HD_BIT] = partner_gig_half_duplex_able;
    indirect_access_control_reg = {r.access_type_field, reserved_bits,
      r.target_device_select};
    // address mode shows the pointer, data modes the MMD word
    indirect_access_data_reg = data_is_mmd ? mmd_rdata : acc.cur_addr;
  end

  // store strobes fire only while the request is being completed
  always_comb
  begin
    acc.load = 1'b0;
    acc.incr = 1'b0;
    acc.load_data = r.req_wdata;
    if (r.st == ST_ACCESS && r.req_off == OFF_ACC_DATA)
    begin
      case (r.access_type_field)
        ACC_ADDRESS: acc.load = r.req_wr;
        ACC_DATA: acc.incr = 1'b0;
        ACC_DATA_POST_INCREMENT_MODE: acc.incr = 1'b1;
        ACC_DATA_POST_INCREMENT_WRITE_MODE: acc.incr = r.req_wr;
        default: acc.incr = 1'b0;
      endcase
    end
  end

  // request sequencer: take, access, reply
  always_comb
  begin
    next_r = r;
    next_r.rd_valid = 1'b0;
    next_r.mmd_rd = 1'b0;
    next_r.mmd_wr = 1'b0;
    case (r.st)
      ST_IDLE:
      begin
        if (reg_rd || reg_wr)
        begin
          next_r.req_off = reg_addr;
          next_r.req_wr = reg_wr;
          next_r.req_wdata = reg_wdata;
          next_r.st = ST_ACCESS;
          // latch the MMD-side request from the selected pointer
          if (reg_addr == OFF_ACC_DATA && data_is_mmd)
          begin
            next_r.mmd_rd = !reg_wr;
            next_r.mmd_wr = reg_wr;
            next_r.mmd_dev = r.target_device_select;
            next_r.mmd_addr = acc.cur_addr;
            next_r.mmd_wdata = reg_wdata;
          end
        end
      end
      ST_ACCESS:
      begin
        next_r.st = ST_REPLY;
        if (r.req_wr)
        begin
          // only the control fields take writes; status and reserved words ignore them
          if (r.req_off == OFF_ACC_CONTROL)
          begin
            next_r.access_type_field =
              access_type_t'(r.req_wdata[ACC_TYPE_HI:ACC_TYPE_LO]);
            next_r.target_device_select = r.req_wdata[DEV_SEL_HI:DEV_SEL_LO];
          end
        end
        else
        begin
          next_r.rd_valid = 1'b1;
          case (r.req_off)
            OFF_GIG_STATUS: next_r.rd_data = gigabit_status_reg;
            OFF_PSE_CONTROL: next_r.rd_data = ZERO_WORD;
            OFF_PSE_STATUS: next_r.rd_data = ZERO_WORD;
            OFF_ACC_CONTROL: next_r.rd_data = indirect_access_control_reg;
            OFF_ACC_DATA: next_r.rd_data = indirect_access_data_reg;
            default: next_r.rd_data = ZERO_WORD;
          endcase
        end
      end
      ST_REPLY:
        next_r.st = ST_IDLE;
      default:
        next_r.st = ST_IDLE;
    endcase
  end

  // one register stage for the whole bank; ce low freezes it
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.access_type_field <= access_type_t'(ACC_CONTROL_RESET[ACC_TYPE_HI:ACC_TYPE_LO]);
      r.target_device_select <= ACC_CONTROL_RESET[DEV_SEL_HI:DEV_SEL_LO];
      r.rd_data <= ACC_DATA_RESET;
    end
    else if (ce)
      r <= next_r;
  end

  // outputs; requests outside idle are not taken, so ready guards them
  assign reg_ready = (r.st == ST_IDLE) && ce;
  assign reg_rdata = r.rd_data;
  assign reg_rvalid = r.rd_valid;
  assign mmd_dev = r.mmd_dev;
  assign mmd_addr = r.mmd_addr;
  assign mmd_wdata = r.mmd_wdata;
  assign mmd_rd = r.mmd_rd;
  assign mmd_wr = r.mmd_wr;

  // status read reports full duplex ability of that cycle
  AST_GIG_FD: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && !r.req_wr && r.req_off == OFF_GIG_STATUS)
    |=> reg_rvalid && reg_rdata[GIG_FD_BIT] == $past(partner_gig_full_duplex_able))
    else $error("full duplex ability bit wrong");

  // status read reports half duplex ability of that cycle
  AST_GIG_HD: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && !r.req_wr && r.req_off == OFF_GIG_STATUS)
    |=> reg_rdata[GIG_HD_BIT] == $past(partner_gig_half_duplex_able))
    else $error("half duplex ability bit wrong");

  // low ten status bits always read zero
  AST_GIG_LOW_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && !r.req_wr && r.req_off == OFF_GIG_STATUS)
    |=> reg_rdata[GIG_LOW_HI:0] == '0)
    else $error("reserved or idle count status bits not zero");

  // both reserved power sourcing words read zero, two cycles after the request
  AST_PSE_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && reg_ready && reg_rd && !reg_wr
      && (reg_addr == OFF_PSE_CONTROL || reg_addr == OFF_PSE_STATUS))
    ##1 ce |=> reg_rvalid && reg_rdata == ZERO_WORD)
    else $error("reserved power sourcing word not zero");

  // control reads back the device select with the gap as zero
  AST_CTRL_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && !r.req_wr && r.req_off == OFF_ACC_CONTROL)
    |=> reg_rdata[ACC_TYPE_LO-1:DEV_SEL_HI+1] == '0
      && reg_rdata[DEV_SEL_HI:DEV_SEL_LO] == r.target_device_select)
    else $error("control read back wrong");

  // a control write lands in the device select field
  AST_DEV_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && r.req_wr && r.req_off == OFF_ACC_CONTROL)
    |=> r.target_device_select == $past(r.req_wdata[DEV_SEL_HI:DEV_SEL_LO]))
    else $error("device select not written");

  // address mode write loads the selected pointer
  AST_ADDR_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && r.req_wr && r.req_off == OFF_ACC_DATA
      && r.access_type_field == ACC_ADDRESS)
    |=> acc.cur_addr == $past(r.req_wdata))
    else $error("pointer not loaded in address mode");

  // data mode request reaches the MMD with selected device and pointer
  AST_MMD_REQ: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_IDLE && (reg_rd || reg_wr) && reg_addr == OFF_ACC_DATA
      && r.access_type_field != ACC_ADDRESS)
    |=> (mmd_rd != mmd_wr) && mmd_dev == $past(r.target_device_select)
      && mmd_addr == $past(acc.cur_addr))
    else $error("mmd request not issued as expected");

  // post increment mode steps the pointer by one
  AST_PI_STEP: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && r.req_off == OFF_ACC_DATA
      && r.access_type_field == ACC_DATA_POST_INCREMENT_MODE)
    |=> acc.cur_addr == $past(acc.cur_addr) + ADDR_STEP)
    else $error("pointer not stepped after access");

  // write-increment mode steps on writes and holds on reads
  AST_PIWR_STEP: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && r.req_off == OFF_ACC_DATA
      && r.access_type_field == ACC_DATA_POST_INCREMENT_WRITE_MODE)
    |=> acc.cur_addr == ($past(r.req_wr) ? $past(acc.cur_addr) + ADDR_STEP
      : $past(acc.cur_addr)))
    else $error("write-increment pointer wrong");

  // plain data and address reads leave the pointer alone
  AST_NO_STEP: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && r.req_off == OFF_ACC_DATA
      && (r.access_type_field == ACC_DATA
        || (r.access_type_field == ACC_ADDRESS && !r.req_wr)))
    |=> $stable(acc.cur_addr))
    else $error("pointer moved without increment mode");

  // address mode read shows the pointer
  AST_ADDR_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && !r.req_wr && r.req_off == OFF_ACC_DATA
      && r.access_type_field == ACC_ADDRESS)
    |=> reg_rdata == $past(acc.cur_addr))
    else $error("address mode read wrong");

  // an MMD strobe lasts exactly one cycle and then the reply follows
  AST_STROBE_ONE: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && (mmd_rd || mmd_wr)) |=> !mmd_rd && !mmd_wr && r.st == ST_REPLY)
    else $error("mmd strobe too long");

  // a synchronous reset clears the control fields
  AST_CTRL_RESET: assert property (@(posedge mclk)
    sys_rst |=> r.access_type_field == ACC_ADDRESS && r.target_device_select == '0)
    else $error("control not cleared by reset");

  // reset leaves no strobe or answer behind
  AST_RESET_QUIET: assert property (@(posedge mclk)
    sys_rst |=> !mmd_rd && !mmd_wr && !reg_rvalid)
    else $error("strobe or answer after reset");

  // a read answer stands for one enabled cycle only
  AST_RVALID_ONE: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && reg_rvalid) |=> !reg_rvalid)
    else $error("read answer held too long");

  // writes never raise a read answer
  AST_WRITE_NO_ANSWER: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && r.req_wr) |=> !reg_rvalid)
    else $error("write produced a read answer");

  // a control write lands in the access type field
  AST_TYPE_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && r.req_wr && r.req_off == OFF_ACC_CONTROL)
    |=> r.access_type_field == $past(r.req_wdata[ACC_TYPE_HI:ACC_TYPE_LO]))
    else $error("access type not written");

  // a control read shows the access type field
  AST_TYPE_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && !r.req_wr && r.req_off == OFF_ACC_CONTROL)
    |=> reg_rdata[ACC_TYPE_HI:ACC_TYPE_LO] == $past(r.access_type_field))
    else $error("access type read back wrong");

  // device select only moves on a control write
  AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && !(r.st == ST_ACCESS && r.req_wr && r.req_off == OFF_ACC_CONTROL))
    |=> $stable(r.target_device_select))
    else $error("device select moved without control write");

  // address mode data accesses stay inside the bank
  AST_ADDR_NO_STROBE: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_IDLE && (reg_rd || reg_wr) && reg_addr == OFF_ACC_DATA
      && r.access_type_field == ACC_ADDRESS)
    |=> !mmd_rd && !mmd_wr)
    else $error("mmd strobe in address mode");

  // a data mode write carries the written word to the MMD
  AST_MMD_WDATA: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_IDLE && reg_wr && reg_addr == OFF_ACC_DATA
      && r.access_type_field != ACC_ADDRESS)
    |=> mmd_wr && !mmd_rd && mmd_wdata == $past(reg_wdata))
    else $error("mmd write data wrong");

  // a data mode read answers with the MMD word of the access cycle
  AST_DATA_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && r.st == ST_ACCESS && !r.req_wr && r.req_off == OFF_ACC_DATA
      && r.access_type_field != ACC_ADDRESS)
    |=> reg_rvalid && reg_rdata == $past(mmd_rdata))
    else $error("data mode read wrong");
endmodule

/* mmd_indirect_access_regs_bench.sv */
// self-checking bench for the indirect access register bank
module mmd_indirect_access_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mmd_access_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [OFF_W-1:0] reg_addr = 5'h00;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [REG_W-1:0] reg_wdata = 16'h0000;
  logic partner_gig_full_duplex_able = 1'b0;
  logic partner_gig_half_duplex_able = 1'b0;
  logic [REG_W-1:0] reg_rdata, mmd_addr, mmd_wdata, mmd_rdata;
  logic reg_rvalid, reg_ready, mmd_rd, mmd_wr;
  logic [DEV_W-1:0] mmd_dev;
  int n_fail = 0;
  int checks = 0;

  // clock, 4 ns period
  always #2 mclk = ~mclk;

  mmd_indirect_access_regs uut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_ready(reg_ready),
    .partner_gig_full_duplex_able(partner_gig_full_duplex_able),
    .partner_gig_half_duplex_able(partner_gig_half_duplex_able),
    .mmd_dev(mmd_dev), .mmd_addr(mmd_addr), .mmd_wdata(mmd_wdata),
    .mmd_rd(mmd_rd), .mmd_wr(mmd_wr), .mmd_rdata(mmd_rdata));

  mmd_space_model model (.mclk(mclk), .mmd_dev(mmd_dev), .mmd_addr(mmd_addr),
    .mmd_wdata(mmd_wdata), .mmd_rd(mmd_rd), .mmd_wr(mmd_wr), .mmd_rdata(mmd_rdata));

  task automatic cmp(input string what, input logic [REG_W-1:0] exp, input logic [REG_W-1:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ready is set by state changed at the rising edge, so the falling edge sees its final value
  task automatic wait_ready;
    int i;
    i = 0;
    @(negedge mclk);
    while (reg_ready !== 1'b1 && i < 10)
    begin
      @(negedge mclk);
      i++;
    end
    if (reg_ready !== 1'b1)
      cmp("reg_ready", 16'h0001, 16'h0000);
  endtask

  task automatic wr(input logic [OFF_W-1:0] a, input logic [REG_W-1:0] d);
    wait_ready();
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // one more cycle lets the write land before its effect is looked at
    @(negedge mclk);
  endtask

  task automatic rd(input logic [OFF_W-1:0] a, output logic [REG_W-1:0] d);
    int i;
    wait_ready();
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    i = 0;
    while (reg_rvalid !== 1'b1 && i < 5)
    begin
      @(negedge mclk);
      i++;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
  endtask

  task automatic chk(input logic [OFF_W-1:0] a, input logic [REG_W-1:0] exp, input string what);
    logic [REG_W-1:0] d;
    rd(a, d);
    cmp(what, exp, d);
  endtask

  task automatic ctl(input access_type_t t, input logic [DEV_W-1:0] dev);
    wr(OFF_ACC_CONTROL, {t, 9'h000, dev});
  endtask

  task automatic t_reset;
    chk(OFF_ACC_CONTROL, 16'h0000, "control reset");
    chk(OFF_ACC_DATA, 16'h0000, "data reset");
  endtask

  // every partner ability pair, then a write that must not stick
  task automatic t_status;
    logic [1:0] k;
    for (int n = 0; n < 4; n++)
    begin
      k = n[1:0];
      partner_gig_full_duplex_able = k[1];
      partner_gig_half_duplex_able = k[0];
      chk(OFF_GIG_STATUS, {4'h0, k, 10'h000}, "gig status");
    end
    // abilities low, so a write that sticks in bits 11:10 would show
    partner_gig_full_duplex_able = 1'b0;
    partner_gig_half_duplex_able = 1'b0;
    wr(OFF_GIG_STATUS, 16'hfc00);
    chk(OFF_GIG_STATUS, 16'h0000, "gig status after write");
  endtask

  task automatic t_reserved;
    wr(OFF_PSE_CONTROL, 16'hffff);
    wr(OFF_PSE_STATUS, 16'hffff);
    chk(OFF_PSE_CONTROL, 16'h0000, "pse control");
    chk(OFF_PSE_STATUS, 16'h0000, "pse status");
    chk(5'h1f, 16'h0000, "unmapped");
  endtask

  task automatic t_control;
    wr(OFF_ACC_CONTROL, 16'hffff);
    chk(OFF_ACC_CONTROL, 16'hc01f, "control all ones");
    wr(OFF_ACC_CONTROL, 16'h7fea);
    chk(OFF_ACC_CONTROL, 16'h400a, "control pattern");
  endtask

  // two MMDs keep their own pointers
  task automatic t_pointers;
    ctl(ACC_ADDRESS, 5'h03);
    wr(OFF_ACC_DATA, 16'h0100);
    ctl(ACC_ADDRESS, 5'h07);
    wr(OFF_ACC_DATA, 16'h0200);
    ctl(ACC_ADDRESS, 5'h03);
    chk(OFF_ACC_DATA, 16'h0100, "pointer mmd3");
    ctl(ACC_ADDRESS, 5'h07);
    chk(OFF_ACC_DATA, 16'h0200, "pointer mmd7");
  endtask

  task automatic t_plain;
    ctl(ACC_DATA, 5'h03);
    wr(OFF_ACC_DATA, 16'habcd);
    cmp("mmd3 word", 16'habcd, model.mem[{5'h03, 16'h0100}]);
    chk(OFF_ACC_DATA, 16'habcd, "plain read");
    ctl(ACC_ADDRESS, 5'h03);
    chk(OFF_ACC_DATA, 16'h0100, "plain no step");
  endtask

  // two writes and a read each step the pointer
  task automatic t_incr;
    ctl(ACC_ADDRESS, 5'h05);
    wr(OFF_ACC_DATA, 16'h0010);
    ctl(ACC_DATA_POST_INCREMENT_MODE, 5'h05);
    wr(OFF_ACC_DATA, 16'h1111);
    wr(OFF_ACC_DATA, 16'h2222);
    chk(OFF_ACC_DATA, 16'h0000, "incr read");
    cmp("mmd5 second word", 16'h2222, model.mem[{5'h05, 16'h0011}]);
    ctl(ACC_ADDRESS, 5'h05);
    chk(OFF_ACC_DATA, 16'h0013, "incr pointer");
  endtask

  // a read leaves the pointer, a write at the top wraps it
  task automatic t_wr_incr;
    ctl(ACC_ADDRESS, 5'h06);
    wr(OFF_ACC_DATA, 16'hffff);
    ctl(ACC_DATA_POST_INCREMENT_WRITE_MODE, 5'h06);
    chk(OFF_ACC_DATA, 16'h0000, "write incr read");
    wr(OFF_ACC_DATA, 16'h5a5a);
    cmp("mmd6 top word", 16'h5a5a, model.mem[{5'h06, 16'hffff}]);
    ctl(ACC_ADDRESS, 5'h06);
    chk(OFF_ACC_DATA, 16'h0000, "write incr pointer");
  endtask

  // a refused write while frozen, then a reset in mid-run
  task automatic t_freeze_reset;
    ctl(ACC_ADDRESS, 5'h09);
    wr(OFF_ACC_DATA, 16'h0042);
    @(negedge mclk);
    ce = 1'b0;
    reg_addr = OFF_ACC_DATA;
    reg_wdata = 16'h0099;
    reg_wr = 1'b1;
    repeat (3) @(negedge mclk);
    cmp("ready while frozen", 16'h0000, {15'h0000, reg_ready});
    reg_wr = 1'b0;
    ce = 1'b1;
    chk(OFF_ACC_DATA, 16'h0042, "frozen pointer");
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    chk(OFF_ACC_CONTROL, 16'h0000, "control after reset");
    ctl(ACC_ADDRESS, 5'h09);
    chk(OFF_ACC_DATA, 16'h0000, "pointer after reset");
  endtask

  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
    t_status();
    t_reserved();
    t_control();
    t_pointers();
    t_plain();
    t_incr();
    t_wr_incr();
    t_freeze_reset();
    finish_test();
  end

  // about 50 requests of a few cycles each need far less than this
  initial
  begin
    #20000;
    n_fail++;
    finish_test();
  end
endmodule

/* mmd_space_model.sv */
// behavioural MMD register space answering the indirect access strobes
module mmd_space_model
  import mmd_access_pkg::*;
(
  // clock
  input wire logic mclk,
  // MMD access from the register bank
  input wire logic [DEV_W-1:0] mmd_dev,
  input wire logic [REG_W-1:0] mmd_addr,
  input wire logic [REG_W-1:0] mmd_wdata,
  input wire logic mmd_rd,
  input wire logic mmd_wr,
  output logic [REG_W-1:0] mmd_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // sparse store keyed by device and address, so a wrong device shows up as a miss
  logic [REG_W-1:0] mem [logic [DEV_W+REG_W-1:0]];
  logic [REG_W-1:0] last = 16'h0000;

  // writes land at the edge that closes the strobe cycle
  always @(posedge mclk)
  begin
    if (mmd_wr === 1'b1)
      mem[{mmd_dev, mmd_addr}] = mmd_wdata;
    if (mmd_rd === 1'b1)
      last <= mmd_rdata;
  end

  // answer within the read cycle; outside it show the inverse so stale data cannot pass
  always @*
  begin
    if (mmd_rd === 1'b1)
      mmd_rdata = mem.exists({mmd_dev, mmd_addr}) ? mem[{mmd_dev, mmd_addr}] : 16'h0000;
    else
      mmd_rdata = ~last;
  end
endmodule
